// ===== hdl/hpc_defs.svh
// offsets, field positions, reset values and timing figures of the hub configuration bank
`ifndef HPC_DEFS_SVH
`define HPC_DEFS_SVH

`define HPC_CLK_PERIOD_NS 10

`define HPC_ADDR_W 8
`define HPC_DATA_W 8
`define HPC_PORTS 2

`define HPC_OFS_POWER_SPEED 8'h07
`define HPC_OFS_DYN_OC 8'h08
`define HPC_OFS_FIXED_PORT 8'h09
`define HPC_OFS_OFF_LOCAL 8'h0A
`define HPC_OFS_OFF_VBUS 8'h0B

`define HPC_RST_POWER_SPEED 8'h00
`define HPC_RST_DYN_OC 8'h00
`define HPC_RST_FIXED_PORT 8'h00
`define HPC_RST_OFF_LOCAL 8'h00
`define HPC_RST_OFF_VBUS 8'h00

// writable bits; everything else is reserved and held at zero
`define HPC_MASK_POWER_SPEED 8'hAE
`define HPC_MASK_DYN_OC 8'hB8
`define HPC_MASK_PORT 8'h06

// power/speed byte fields
`define HPC_BIT_POWER_SOURCE 7
`define HPC_BIT_FULL_SPEED_ONLY 5
`define HPC_BIT_EOP_SUPPRESS 3
`define HPC_BIT_SENSE_NONE 2
`define HPC_BIT_SENSE_LO 1

// dynamic/over-current byte fields
`define HPC_BIT_DYNAMIC 7
`define HPC_BIT_DELAY_HI 5
`define HPC_BIT_DELAY_LO 4
`define HPC_BIT_COMPOUND 3

// port bit positions inside the port registers
`define HPC_BIT_PORT1 1
`define HPC_BIT_PORT2 2

// over-current delay figures in ns
`define HPC_OC_T0_NS 100000
`define HPC_OC_T1_NS 2000000
`define HPC_OC_T2_NS 4000000
`define HPC_OC_T3_NS 6000000

`define HPC_OC_CNT_W 20
`define HPC_ONE_CNT 20'h00001
`define HPC_ZERO_CNT 20'h00000

`endif

// ===== hdl/hpc_pkg.sv
// types shared by the hub configuration bank
package hpc_pkg;

    typedef enum logic [1:0]
    {
        HPC_DELAY_0P1MS = 2'h0,
        HPC_DELAY_2MS = 2'h1,
        HPC_DELAY_4MS = 2'h2,
        HPC_DELAY_6MS = 2'h3
    } hpc_oc_delay_t;

    typedef enum logic [2:0]
    {
        HPC_OC_IDLE = 3'h1,
        HPC_OC_WAIT = 3'h2,
        HPC_OC_FAULT = 3'h4
    } hpc_oc_state_t;

endpackage

// ===== hdl/hpc_oc_if.sv
// carrier between the config bank and its over-current delay timer
`timescale 1ns/10ps
interface hpc_oc_if;
    import hpc_pkg::*;
    logic sense_en;
    logic raw;
    hpc_oc_delay_t sel;
    logic fault;

    modport bank (output sense_en, output raw, output sel, input fault);
    modport timer (input sense_en, input raw, input sel, output fault);
endinterface

// ===== hdl/hpc_overcurrent_delay_select.sv
// over-current qualification timer with selectable delay
`timescale 1ns/10ps
`include "hpc_defs.svh"
module hpc_overcurrent_delay_select
    import hpc_pkg::*;
#(
    parameter logic [`HPC_OC_CNT_W-1:0] CNT_0 = `HPC_OC_CNT_W'(`HPC_OC_T0_NS / `HPC_CLK_PERIOD_NS),
    parameter logic [`HPC_OC_CNT_W-1:0] CNT_1 = `HPC_OC_CNT_W'(`HPC_OC_T1_NS / `HPC_CLK_PERIOD_NS),
    parameter logic [`HPC_OC_CNT_W-1:0] CNT_2 = `HPC_OC_CNT_W'(`HPC_OC_T2_NS / `HPC_CLK_PERIOD_NS),
    parameter logic [`HPC_OC_CNT_W-1:0] CNT_3 = `HPC_OC_CNT_W'(`HPC_OC_T3_NS / `HPC_CLK_PERIOD_NS)
)
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    hpc_oc_if.timer oc
);

    hpc_oc_state_t state;
    hpc_oc_state_t next_state;
    logic [`HPC_OC_CNT_W-1:0] count;
    logic [`HPC_OC_CNT_W-1:0] next_count;
    logic [`HPC_OC_CNT_W-1:0] limit;
    logic active;
    logic expired;

    assign active = oc.sense_en & oc.raw;
    assign expired = (count + `HPC_ONE_CNT) >= limit;

    always_comb
    begin
        case (oc.sel)
            HPC_DELAY_0P1MS: limit = CNT_0;
            HPC_DELAY_2MS: limit = CNT_1;
            HPC_DELAY_4MS: limit = CNT_2;
            HPC_DELAY_6MS: limit = CNT_3;
            default: limit = CNT_0;
        endcase
    end

    // fault shows only after the condition held for the whole delay
    always_comb
    begin
        next_state = state;
        next_count = count;
        case (state)
            HPC_OC_IDLE:
            begin
                next_count = `HPC_ZERO_CNT;
                if (active)
                    next_state = HPC_OC_WAIT;
            end
            HPC_OC_WAIT:
            begin
                if (!active)
                begin
                    next_state = HPC_OC_IDLE;
                    next_count = `HPC_ZERO_CNT;
                end
                else if (expired)
                    next_state = HPC_OC_FAULT;
                else
                    next_count = count + `HPC_ONE_CNT;
            end
            HPC_OC_FAULT:
            begin
                next_count = `HPC_ZERO_CNT;
                if (!active)
                    next_state = HPC_OC_IDLE;
            end
            default:
            begin
                next_state = HPC_OC_IDLE;
                next_count = `HPC_ZERO_CNT;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state <= HPC_OC_IDLE;
            count <= `HPC_ZERO_CNT;
            oc.fault <= 1'b0;
        end
        else if (ce_i)
        begin
            state <= next_state;
            count <= next_count;
            oc.fault <= (next_state == HPC_OC_FAULT);
        end
    end

endmodule // hpc_overcurrent_delay_select

// ===== hdl/hpc_cfg_regs.sv
// hub power, speed and port configuration register bank
`timescale 1ns/10ps
`include "hpc_defs.svh"
module hpc_cfg_regs
    import hpc_pkg::*;
#(
    parameter logic [`HPC_OC_CNT_W-1:0] OC_CNT_0 = `HPC_OC_CNT_W'(`HPC_OC_T0_NS / `HPC_CLK_PERIOD_NS),
    parameter logic [`HPC_OC_CNT_W-1:0] OC_CNT_1 = `HPC_OC_CNT_W'(`HPC_OC_T1_NS / `HPC_CLK_PERIOD_NS),
    parameter logic [`HPC_OC_CNT_W-1:0] OC_CNT_2 = `HPC_OC_CNT_W'(`HPC_OC_T2_NS / `HPC_CLK_PERIOD_NS),
    parameter logic [`HPC_OC_CNT_W-1:0] OC_CNT_3 = `HPC_OC_CNT_W'(`HPC_OC_T3_NS / `HPC_CLK_PERIOD_NS)
)
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [`HPC_ADDR_W-1:0] cfg_addr_i,
    input wire logic [`HPC_DATA_W-1:0] cfg_wdata_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic config_lock_i,
    input wire logic local_power_present_pin_i,
    input wire logic overcurrent_raw_i,
    output logic [`HPC_DATA_W-1:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    output logic cfg_hit_o,
    output logic cfg_wr_refused_o,
    output logic locked_o,
    output logic self_powered_o,
    output logic full_speed_only_o,
    output logic frame_end_packet_suppress_o,
    output logic overcurrent_sense_ganged_o,
    output logic overcurrent_sense_off_o,
    output logic sense_conflict_o,
    output logic overcurrent_fault_o,
    output logic compound_device_o,
    output logic [`HPC_PORTS-1:0] fixed_port_bits_o,
    output logic [`HPC_PORTS-1:0] port_enable_o
);

    logic [`HPC_DATA_W-1:0] hub_power_speed_config;
    logic [`HPC_DATA_W-1:0] hub_dynamic_overcurrent_config;
    logic [`HPC_DATA_W-1:0] fixed_port_mask;
    logic [`HPC_DATA_W-1:0] port_off_mask_local_power;
    logic [`HPC_DATA_W-1:0] port_off_mask_vbus_power;
    logic lock;

    hpc_oc_if oc_link ();

    // address decode
    wire sel_power_speed = (cfg_addr_i == `HPC_OFS_POWER_SPEED);
    wire sel_dyn_oc = (cfg_addr_i == `HPC_OFS_DYN_OC);
    wire sel_fixed_port = (cfg_addr_i == `HPC_OFS_FIXED_PORT);
    wire sel_off_local = (cfg_addr_i == `HPC_OFS_OFF_LOCAL);
    wire sel_off_vbus = (cfg_addr_i == `HPC_OFS_OFF_VBUS);
    wire addr_hit = sel_power_speed | sel_dyn_oc | sel_fixed_port | sel_off_local | sel_off_vbus;

    // the lock is sampled as a level; once seen it holds until reset
    wire next_lock = lock | config_lock_i;
    wire wr_ok = cfg_wr_i & addr_hit & ~lock;
    wire wr_refused = cfg_wr_i & addr_hit & lock;

    // reserved bits are masked off on every write
    wire [`HPC_DATA_W-1:0] wdata_power_speed = cfg_wdata_i & `HPC_MASK_POWER_SPEED;
    wire [`HPC_DATA_W-1:0] wdata_dyn_oc = cfg_wdata_i & `HPC_MASK_DYN_OC;
    wire [`HPC_DATA_W-1:0] wdata_port = cfg_wdata_i & `HPC_MASK_PORT;

    wire [`HPC_DATA_W-1:0] next_power_speed = (wr_ok & sel_power_speed) ? wdata_power_speed
                                                                         : hub_power_speed_config;
    wire [`HPC_DATA_W-1:0] next_dyn_oc = (wr_ok & sel_dyn_oc) ? wdata_dyn_oc : hub_dynamic_overcurrent_config;
    wire [`HPC_DATA_W-1:0] next_fixed_port = (wr_ok & sel_fixed_port) ? wdata_port : fixed_port_mask;
    wire [`HPC_DATA_W-1:0] next_off_local = (wr_ok & sel_off_local) ? wdata_port : port_off_mask_local_power;
    wire [`HPC_DATA_W-1:0] next_off_vbus = (wr_ok & sel_off_vbus) ? wdata_port : port_off_mask_vbus_power;

    // read mux; unmapped offsets read zero
    wire [`HPC_DATA_W-1:0] rd_mux =
        sel_power_speed ? hub_power_speed_config :
        sel_dyn_oc ? hub_dynamic_overcurrent_config :
        sel_fixed_port ? fixed_port_mask :
        sel_off_local ? port_off_mask_local_power :
        sel_off_vbus ? port_off_mask_vbus_power :
        `HPC_DATA_W'(0);
    wire [`HPC_DATA_W-1:0] next_rdata = cfg_rd_i ? rd_mux : cfg_rdata_o;

    // field decode from the stored bytes
    wire stored_self = hub_power_speed_config[`HPC_BIT_POWER_SOURCE];
    wire dynamic_en = hub_dynamic_overcurrent_config[`HPC_BIT_DYNAMIC];
    // dynamic mode follows the pin both ways: loss drops to bus, return restores self
    wire next_self = dynamic_en ? local_power_present_pin_i : stored_self;
    wire next_fs_only = hub_power_speed_config[`HPC_BIT_FULL_SPEED_ONLY];
    wire next_eop_supp = hub_power_speed_config[`HPC_BIT_EOP_SUPPRESS];
    wire sense_none = hub_power_speed_config[`HPC_BIT_SENSE_NONE];
    // reserved code 01 is handled like ganged sensing
    wire next_ganged = ~sense_none;
    wire next_conflict = sense_none & next_self;
    wire next_compound = hub_dynamic_overcurrent_config[`HPC_BIT_COMPOUND];
    wire [`HPC_PORTS-1:0] next_fixed = fixed_port_mask[`HPC_BIT_PORT2:`HPC_BIT_PORT1];
    wire [`HPC_PORTS-1:0] off_now = next_self ? port_off_mask_local_power[`HPC_BIT_PORT2:`HPC_BIT_PORT1]
                                              : port_off_mask_vbus_power[`HPC_BIT_PORT2:`HPC_BIT_PORT1];
    wire [`HPC_PORTS-1:0] next_port_en = ~off_now;

    assign oc_link.sense_en = ~sense_none;
    assign oc_link.raw = overcurrent_raw_i;
    assign oc_link.sel =
        hpc_oc_delay_t'(hub_dynamic_overcurrent_config[`HPC_BIT_DELAY_HI:`HPC_BIT_DELAY_LO]);

    hpc_overcurrent_delay_select #(
        .CNT_0(OC_CNT_0),
        .CNT_1(OC_CNT_1),
        .CNT_2(OC_CNT_2),
        .CNT_3(OC_CNT_3)
    ) u_overcurrent_delay_select (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .oc(oc_link.timer)
    );

    // register storage
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            hub_power_speed_config <= `HPC_RST_POWER_SPEED;
            hub_dynamic_overcurrent_config <= `HPC_RST_DYN_OC;
            fixed_port_mask <= `HPC_RST_FIXED_PORT;
            port_off_mask_local_power <= `HPC_RST_OFF_LOCAL;
            port_off_mask_vbus_power <= `HPC_RST_OFF_VBUS;
            lock <= 1'b0;
        end
        else if (ce_i)
        begin
            hub_power_speed_config <= next_power_speed;
            hub_dynamic_overcurrent_config <= next_dyn_oc;
            fixed_port_mask <= next_fixed_port;
            port_off_mask_local_power <= next_off_local;
            port_off_mask_vbus_power <= next_off_vbus;
            lock <= next_lock;
        end
    end

    // register port answers
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cfg_rdata_o <= `HPC_DATA_W'(0);
            cfg_rvalid_o <= 1'b0;
            cfg_hit_o <= 1'b0;
            cfg_wr_refused_o <= 1'b0;
            locked_o <= 1'b0;
        end
        else if (ce_i)
        begin
            cfg_rdata_o <= next_rdata;
            cfg_rvalid_o <= cfg_rd_i;
            cfg_hit_o <= (cfg_rd_i | cfg_wr_i) & addr_hit;
            cfg_wr_refused_o <= wr_refused;
            locked_o <= next_lock;
        end
    end

    // hub core controls
    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            self_powered_o <= 1'b0;
            full_speed_only_o <= 1'b0;
            frame_end_packet_suppress_o <= 1'b0;
            overcurrent_sense_ganged_o <= 1'b1;
            overcurrent_sense_off_o <= 1'b0;
            sense_conflict_o <= 1'b0;
            overcurrent_fault_o <= 1'b0;
            compound_device_o <= 1'b0;
            fixed_port_bits_o <= `HPC_PORTS'(0);
            port_enable_o <= {`HPC_PORTS{1'b1}};
        end
        else if (ce_i)
        begin
            self_powered_o <= next_self;
            full_speed_only_o <= next_fs_only;
            frame_end_packet_suppress_o <= next_eop_supp;
            overcurrent_sense_ganged_o <= next_ganged;
            overcurrent_sense_off_o <= sense_none;
            sense_conflict_o <= next_conflict;
            overcurrent_fault_o <= oc_link.fault;
            compound_device_o <= next_compound;
            fixed_port_bits_o <= next_fixed;
            port_enable_o <= next_port_en;
        end
    end

endmodule // hpc_cfg_regs

// ===== tb/hpc_cfg_regs_sva.sv
// port assertions for the hub configuration bank
`timescale 1ns/10ps
module hpc_cfg_regs_sva
#(
    parameter logic [19:0] OC_CNT_0 = 20'h00004
)
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic config_lock_i,
    input wire logic overcurrent_raw_i,
    input wire logic [7:0] cfg_rdata_o,
    input wire logic cfg_rvalid_o,
    input wire logic cfg_hit_o,
    input wire logic cfg_wr_refused_o,
    input wire logic locked_o,
    input wire logic overcurrent_sense_ganged_o,
    input wire logic overcurrent_sense_off_o,
    input wire logic overcurrent_fault_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    logic [19:0] raw_run;
    wire rd_go = cfg_rd_i && ce_i;
    wire mapped = cfg_addr_i >= 8'h07 && cfg_addr_i <= 8'h0B;
    // bits that must read zero at the addressed offset
    wire [7:0] rsv = cfg_addr_i == 8'h07 ? 8'h51 : cfg_addr_i == 8'h08 ? 8'h47 : mapped ? 8'hF9 : 8'hFF;
    always_ff @(posedge clk_sys_i or negedge resetn_i)
        if (!resetn_i)
            raw_run <= 20'h00000;
        else
            raw_run <= overcurrent_raw_i ? raw_run + 20'h00001 : 20'h00000;
    sequence s_locked_wr;
        // writes are gated by the registered lock only
        cfg_wr_i && ce_i && mapped && locked_o;
    endsequence
    sequence s_raw_low;
        !overcurrent_raw_i [*3];
    endsequence
    // read valid holds its value while the clock enable is low
    AST_RVALID: assert property (1'b1 |=> cfg_rvalid_o == ($past(ce_i) ? $past(cfg_rd_i) : $past(cfg_rvalid_o)))
        else $error("read valid wrong");
    AST_RSV_ZERO: assert property (rd_go |=> (cfg_rdata_o & $past(rsv)) == 8'h00)
        else $error("reserved bit set");
    AST_HIT: assert property ((cfg_rd_i || cfg_wr_i) && ce_i |=> cfg_hit_o == $past(mapped)) else $error("hit wrong");
    AST_LOCK_SET: assert property (config_lock_i && ce_i |=> locked_o) else $error("lock not taken");
    AST_LOCK_HOLD: assert property (locked_o |=> locked_o) else $error("lock dropped");
    AST_REFUSE: assert property (s_locked_wr |=> cfg_wr_refused_o)
        else $error("locked write not refused");
    AST_REFUSE_CAUSE: assert property (cfg_wr_refused_o |-> $past(cfg_wr_i) && $past(locked_o))
        else $error("refusal without locked write");
    AST_SENSE_EXCL: assert property (overcurrent_sense_ganged_o != overcurrent_sense_off_o)
        else $error("sense mode");
    AST_FAULT_MIN: assert property ($rose(overcurrent_fault_o) |-> raw_run >= OC_CNT_0)
        else $error("fault early");
    AST_FAULT_DROP: assert property (s_raw_low |-> !overcurrent_fault_o) else $error("fault held");
    AST_FAULT_OFF: assert property (overcurrent_sense_off_o [*3] |-> !overcurrent_fault_o)
        else $error("fault unsensed");
endmodule // hpc_cfg_regs_sva

bind hpc_cfg_regs hpc_cfg_regs_sva #(.OC_CNT_0(OC_CNT_0)) hpc_cfg_regs_sva_i (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .ce_i(ce_i), .cfg_addr_i(cfg_addr_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
    .config_lock_i(config_lock_i), .overcurrent_raw_i(overcurrent_raw_i), .cfg_rdata_o(cfg_rdata_o),
    .cfg_rvalid_o(cfg_rvalid_o), .cfg_hit_o(cfg_hit_o), .cfg_wr_refused_o(cfg_wr_refused_o), .locked_o(locked_o),
    .overcurrent_sense_ganged_o(overcurrent_sense_ganged_o), .overcurrent_sense_off_o(overcurrent_sense_off_o),
    .overcurrent_fault_o(overcurrent_fault_o));

// ===== tb/hpc_host_model.sv
// configuring host: byte writes, byte reads and the lock level
`timescale 1ns/10ps
module hpc_host_model
(
    input wire logic clk_sys_i,
    input wire logic [7:0] cfg_rdata_i,
    output logic [7:0] cfg_addr_o = 8'h00,
    output logic [7:0] cfg_wdata_o = 8'h00,
    output logic cfg_wr_o = 1'b0,
    output logic cfg_rd_o = 1'b0,
    output logic config_lock_o = 1'b0
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        cfg_addr_o <= a;
        cfg_wdata_o <= d;
        cfg_wr_o <= 1'b1;
        @(posedge clk_sys_i);
        cfg_wr_o <= 1'b0;
        cfg_wdata_o <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        cfg_addr_o <= a;
        cfg_rd_o <= 1'b1;
        @(posedge clk_sys_i);
        cfg_rd_o <= 1'b0;
        #1;
        d = cfg_rdata_i;
    endtask
    // lock raised once configuration is loaded
    task automatic set_lock();
        @(posedge clk_sys_i);
        config_lock_o <= 1'b1;
        @(posedge clk_sys_i);
        config_lock_o <= 1'b0;
    endtask
endmodule // hpc_host_model

// ===== tb/test_hpc_cfg_regs.sv
// self-checking bench for the hub configuration bank
`timescale 1ns/10ps
module test_hpc_cfg_regs;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ce = 1'b1;
    logic pin = 1'b0;
    logic raw = 1'b0;
    wire [7:0] addr, wdata, rdata;
    wire wr, rd, lock, rv, hit, refused, locked, selfp, fso, eop, gang, soff, conf, fault, comp;
    wire [1:0] fixed, pen;
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;
    logic [7:0] d, v;
    logic [7:0] mask [7:11] = '{8'hAE, 8'hB8, 8'h06, 8'h06, 8'h06};
    // power/speed codes; sense-off codes only with bus power
    logic [7:0] cfg1 [7] = '{8'h00, 8'h80, 8'h20, 8'h08, 8'h02, 8'h04, 8'hA8};
    hpc_host_model hpc_host_model_i (.clk_sys_i(clk_sys_i), .cfg_rdata_i(rdata), .cfg_addr_o(addr),
        .cfg_wdata_o(wdata), .cfg_wr_o(wr), .cfg_rd_o(rd), .config_lock_o(lock));
    hpc_cfg_regs #(.OC_CNT_0(20'h00004), .OC_CNT_1(20'h00008), .OC_CNT_2(20'h0000C), .OC_CNT_3(20'h00010))
    hpc_cfg_regs_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(ce), .cfg_addr_i(addr),
        .cfg_wdata_i(wdata), .cfg_wr_i(wr), .cfg_rd_i(rd), .config_lock_i(lock), .local_power_present_pin_i(pin),
        .overcurrent_raw_i(raw), .cfg_rdata_o(rdata), .cfg_rvalid_o(rv), .cfg_hit_o(hit),
        .cfg_wr_refused_o(refused), .locked_o(locked), .self_powered_o(selfp), .full_speed_only_o(fso),
        .frame_end_packet_suppress_o(eop), .overcurrent_sense_ganged_o(gang), .overcurrent_sense_off_o(soff),
        .sense_conflict_o(conf), .overcurrent_fault_o(fault), .compound_device_o(comp),
        .fixed_port_bits_o(fixed), .port_enable_o(pen));
    initial
    begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        hpc_host_model_i.rd(a, d);
        check("rdata", d, exp);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failures++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (20) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        for (logic [7:0] a = 8'h07; a <= 8'h0B; a++)
            rdchk(a, 8'h00);
        rdchk(8'h0C, 8'h00);
        check("pen", pen, 8'h03);
        $display("test reset done");
        for (logic [7:0] a = 8'h07; a <= 8'h0B; a++)
        begin
            hpc_host_model_i.wr(a, 8'h7F);
            rdchk(a, 8'h7F & mask[a]);
        end
        settle();
        check("outs", {selfp, fso, eop, gang, soff, conf, comp, 1'b0}, 8'h6A);
        check("ports", {4'h0, fixed, pen}, 8'h0C);
        // a write while the clock enable is low must not land
        @(posedge clk_sys_i);
        ce <= 1'b0;
        hpc_host_model_i.wr(8'h09, 8'h00);
        ce <= 1'b1;
        rdchk(8'h09, 8'h06);
        $display("test reserved done");
        hpc_host_model_i.wr(8'h08, 8'h00);
        hpc_host_model_i.wr(8'h09, 8'h04);
        hpc_host_model_i.wr(8'h0A, 8'h04);
        hpc_host_model_i.wr(8'h0B, 8'h02);
        foreach (cfg1[k])
        begin
            v = cfg1[k];
            hpc_host_model_i.wr(8'h07, v);
            settle();
            d = {3'h0, v[7], v[5], v[3], ~v[2], v[2]};
            check("cfg1", {selfp, fso, eop, gang, soff}, d);
            check("pen", pen, v[7] ? 8'h01 : 8'h02);
        end
        // sensing off while self powered raises the warning
        hpc_host_model_i.wr(8'h07, 8'h84);
        settle();
        check("conflict", {conf, soff, selfp}, 8'h07);
        check("fixed", fixed, 8'h02);
        $display("test fields done");
        hpc_host_model_i.wr(8'h07, 8'h00);
        hpc_host_model_i.wr(8'h08, 8'h88);
        for (int p = 0; p < 3; p++)
        begin
            // stored bit set on the last pass must still be ignored
            hpc_host_model_i.wr(8'h07, {p[1], 7'h00});
            @(posedge clk_sys_i);
            pin <= p[0];
            settle();
            check("dyn", {comp, selfp, pen}, p[0] ? 8'h0D : 8'h0A);
        end
        $display("test dynamic done");
        for (int c = 0; c < 4; c++)
        begin
            hpc_host_model_i.wr(8'h08, {2'h0, c[1:0], 4'h0});
            settle();
            @(posedge clk_sys_i);
            raw <= 1'b1;
            n = 0;
            while (fault !== 1'b1 && n < 40)
            begin
                @(posedge clk_sys_i);
                #1;
                n++;
            end
            check("oc_delay", n >= 4 * (c + 1) && n <= 4 * (c + 1) + 3, 8'h01);
            @(posedge clk_sys_i);
            raw <= 1'b0;
            settle();
            check("oc_clear", fault, 8'h00);
        end
        hpc_host_model_i.wr(8'h07, 8'h04);
        raw <= 1'b1;
        repeat (30) @(posedge clk_sys_i);
        #1;
        check("oc_off", fault, 8'h00);
        @(posedge clk_sys_i);
        raw <= 1'b0;
        $display("test overcurrent done");
        hpc_host_model_i.set_lock();
        hpc_host_model_i.wr(8'h09, 8'h02);
        #1;
        check("refused", refused, 8'h01);
        rdchk(8'h09, 8'h04);
        @(posedge clk_sys_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        hpc_host_model_i.wr(8'h09, 8'h02);
        rdchk(8'h09, 8'h02);
        rdchk(8'h07, 8'h00);
        $display("test lock done");
        print_verdict();
    end
endmodule // test_hpc_cfg_regs
